// ==== src/mic_defines.vh ====
// Constants shared by the interrupt controller files
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MIC_OFS_EDGE_CFG 8'h05
`define MIC_OFS_CPU_STATUS 8'h06
`define MIC_OFS_STATUS_CTRL 8'h07
`define MIC_OFS_PERIPH_REQ 8'h16
`define MIC_OFS_PERIPH_EN 8'h17

// ----------------------------------------------------------------
// Field positions of the status/control register
// ----------------------------------------------------------------
`define MIC_BIT_PERIPH_PEND 7
`define MIC_BIT_TCLK_FLAG 6
`define MIC_BIT_T0_FLAG 5
`define MIC_BIT_EXT_FLAG 4
`define MIC_BIT_PERIPH_EN 3
`define MIC_BIT_TCLK_EN 2
`define MIC_BIT_T0_EN 1
`define MIC_BIT_EXT_EN 0

// ----------------------------------------------------------------
// Other field positions
// ----------------------------------------------------------------
`define MIC_BIT_GLOBAL_DIS 4
`define MIC_BIT_PORTB_REQ 7
`define MIC_BIT_EXT_RISE 0
`define MIC_BIT_TCLK_RISE 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MIC_RST_STATUS_CTRL 8'h00
`define MIC_RST_CPU_STATUS 8'h10
`define MIC_RST_PERIPH_REQ 8'h02
`define MIC_RST_PERIPH_EN 8'h00
`define MIC_RST_EDGE_CFG 8'h00

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define MIC_VEC_RESET 16'h0000
`define MIC_VEC_EXT 16'h0008
`define MIC_VEC_T0 16'h0010
`define MIC_VEC_TCLK 16'h0018
`define MIC_VEC_PERIPH 16'h0020

`endif

// ==== src/mic_edge_det.v ====
// Pin synchroniser with selectable edge detection
`timescale 1ns/1ps
`default_nettype none

module mic_edge_det (
  input wire clk,
  input wire rstn,
  input wire pin,
  input wire rise_sel,
  output wire edge_pulse
);

  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then one delay stage for the edge
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Edge compare only uses stages after the first flop
  assign edge_pulse = rise_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);

endmodule
`default_nettype wire

// ==== src/mic_irq_ctrl.v ====
// Interrupt controller of the microcontroller core: flags, enables, vectors, stack
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_defines.vh"

module mic_irq_ctrl #(
  parameter STACK_DEPTH = 16,
  parameter SP_W = 4,
  parameter PC_W = 16
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire ext_irq_pin,
  input wire timer_clk_input_pin,
  input wire [7:0] port_b_pins,
  input wire timer0_ovf,
  input wire [6:0] periph_evt,
  input wire instr_boundary,
  input wire [PC_W-1:0] return_pc,
  input wire return_from_irq_instr,
  output wire irq_req,
  output reg vec_take,
  output reg [PC_W-1:0] vec_addr,
  output reg pc_load,
  output reg [PC_W-1:0] pc_value,
  output wire global_irq_disable
);

  // ----------------------------------------------------------------
  // Source selection codes for the vector decision
  // ----------------------------------------------------------------
  localparam SRC_NONE = 3'd0;
  localparam SRC_EXT = 3'd1;
  localparam SRC_T0 = 3'd2;
  localparam SRC_TCLK = 3'd3;
  localparam SRC_PERIPH = 3'd4;
  localparam SRC_SPUR = 3'd5;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] irq_status_ctrl_reg;
  reg [7:0] irq_status_ctrl_next;
  reg [7:0] cpu_status_reg;
  reg [7:0] cpu_status_next;
  reg [7:0] periph_irq_request_reg;
  reg [7:0] periph_irq_request_next;
  reg [7:0] periph_irq_enable_reg;
  reg [7:0] edge_cfg_reg;
  reg [7:0] portb_sync1_reg;
  reg [7:0] portb_sync2_reg;
  reg [7:0] portb_prev_reg;
  reg spurious_reg;
  reg spurious_next;
  reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  reg [SP_W-1:0] sp_reg;
  reg [2:0] src_sel;

  wire ext_edge;
  wire tclk_edge;
  wire portb_change;
  wire [7:0] periph_set;
  wire periph_pending_flag;
  wire wr_status;
  wire wr_cpu;
  wire wr_preq;
  wire take;
  wire [2:0] en_cleared;
  wire [2:0] flag_events;

  // Field views of the status/control register
  wire timer_clk_pin_edge_flag = irq_status_ctrl_reg[`MIC_BIT_TCLK_FLAG];
  wire timer0_overflow_flag = irq_status_ctrl_reg[`MIC_BIT_T0_FLAG];
  wire ext_pin_edge_flag = irq_status_ctrl_reg[`MIC_BIT_EXT_FLAG];
  wire periph_group_enable = irq_status_ctrl_reg[`MIC_BIT_PERIPH_EN];
  wire timer_clk_pin_edge_enable = irq_status_ctrl_reg[`MIC_BIT_TCLK_EN];
  wire timer0_overflow_enable = irq_status_ctrl_reg[`MIC_BIT_T0_EN];
  wire ext_pin_edge_enable = irq_status_ctrl_reg[`MIC_BIT_EXT_EN];

  // ----------------------------------------------------------------
  // Helper: wrap-around stack pointer step
  // ----------------------------------------------------------------
  function [SP_W-1:0] sp_step;
    input [SP_W-1:0] sp;
    input up;
    begin
      if (up) begin
        sp_step = (sp == STACK_DEPTH[SP_W-1:0] - 1'b1) ? {SP_W{1'b0}} : sp + 1'b1;
      end else begin
        sp_step = (sp == {SP_W{1'b0}}) ? STACK_DEPTH[SP_W-1:0] - 1'b1 : sp - 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  // external latency
  // Pins pass two flops plus an edge stage before a flag can rise
  mic_edge_det u_ext_edge (
    .clk(clk),
    .rstn(rstn),
    .pin(ext_irq_pin),
    .rise_sel(edge_cfg_reg[`MIC_BIT_EXT_RISE]),
    .edge_pulse(ext_edge)
  );

  mic_edge_det u_tclk_edge (
    .clk(clk),
    .rstn(rstn),
    .pin(timer_clk_input_pin),
    .rise_sel(edge_cfg_reg[`MIC_BIT_TCLK_RISE]),
    .edge_pulse(tclk_edge)
  );

  always @(posedge clk) begin
    if (!rstn) begin
      portb_sync1_reg <= 8'h00;
      portb_sync2_reg <= 8'h00;
      portb_prev_reg <= 8'h00;
    end else begin
      portb_sync1_reg <= port_b_pins;
      portb_sync2_reg <= portb_sync1_reg;
      portb_prev_reg <= portb_sync2_reg;
    end
  end

  assign portb_change = |(portb_sync2_reg ^ portb_prev_reg);
  assign periph_set = {portb_change, periph_evt};
  assign flag_events = {tclk_edge, timer0_ovf, ext_edge};

  assign periph_pending_flag = |(periph_irq_request_reg & periph_irq_enable_reg);

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  assign wr_status = reg_wr && (reg_addr == `MIC_OFS_STATUS_CTRL);
  assign wr_cpu = reg_wr && (reg_addr == `MIC_OFS_CPU_STATUS);
  assign wr_preq = reg_wr && (reg_addr == `MIC_OFS_PERIPH_REQ);

  assign en_cleared = wr_status ? (irq_status_ctrl_reg[2:0] & ~reg_wdata[2:0]) : 3'b000;

  // ----------------------------------------------------------------
  // Vector decision
  // ----------------------------------------------------------------
  // fixed priority
  always @* begin
    src_sel = SRC_NONE;
    if (spurious_reg) begin
      src_sel = SRC_SPUR;
    end else if (ext_pin_edge_flag && ext_pin_edge_enable) begin
      src_sel = SRC_EXT;
    end else if (timer0_overflow_flag && timer0_overflow_enable) begin
      src_sel = SRC_T0;
    end else if (timer_clk_pin_edge_flag && timer_clk_pin_edge_enable) begin
      src_sel = SRC_TCLK;
    end else if (periph_pending_flag && periph_group_enable) begin
      src_sel = SRC_PERIPH;
    end
  end

  assign irq_req = (src_sel != SRC_NONE) && !cpu_status_reg[`MIC_BIT_GLOBAL_DIS];
  // instruction boundary
  // Two-cycle instructions hold off the boundary and so add one cycle
  assign take = irq_req && instr_boundary;
  assign global_irq_disable = cpu_status_reg[`MIC_BIT_GLOBAL_DIS];

  // ----------------------------------------------------------------
  // Next values of the status/control, CPU status and peripheral request registers
  // ----------------------------------------------------------------
  always @* begin
    irq_status_ctrl_next = irq_status_ctrl_reg;
    if (wr_status) begin
      irq_status_ctrl_next[6:0] = reg_wdata[6:0];
    end
    if (take) begin
      case (src_sel)
        SRC_EXT: irq_status_ctrl_next[`MIC_BIT_EXT_FLAG] = 1'b0;
        SRC_T0: irq_status_ctrl_next[`MIC_BIT_T0_FLAG] = 1'b0;
        SRC_TCLK: irq_status_ctrl_next[`MIC_BIT_TCLK_FLAG] = 1'b0;
        default: irq_status_ctrl_next[`MIC_BIT_PERIPH_PEND] = 1'b0;
      endcase
    end
    // flags set regardless
    // Hardware set wins over software or vector clear in the same cycle
    if (flag_events[0]) begin
      irq_status_ctrl_next[`MIC_BIT_EXT_FLAG] = 1'b1;
    end
    if (flag_events[1]) begin
      irq_status_ctrl_next[`MIC_BIT_T0_FLAG] = 1'b1;
    end
    if (flag_events[2]) begin
      irq_status_ctrl_next[`MIC_BIT_TCLK_FLAG] = 1'b1;
    end
    irq_status_ctrl_next[`MIC_BIT_PERIPH_PEND] = 1'b0;
  end

  always @* begin
    cpu_status_next = cpu_status_reg;
    if (wr_cpu) begin
      cpu_status_next[`MIC_BIT_GLOBAL_DIS] = reg_wdata[`MIC_BIT_GLOBAL_DIS];
    end
    if (return_from_irq_instr) begin
      cpu_status_next[`MIC_BIT_GLOBAL_DIS] = 1'b0;
    end
    if (take) begin
      cpu_status_next[`MIC_BIT_GLOBAL_DIS] = 1'b1;
    end
  end

  always @* begin
    periph_irq_request_next = periph_irq_request_reg;
    if (wr_preq) begin
      periph_irq_request_next = reg_wdata;
    end
    periph_irq_request_next = periph_irq_request_next | periph_set;
  end

  // spurious reset vector
  // The dedicated flag events and the peripheral request events of this cycle are checked against the cleared enables
  always @* begin
    spurious_next = spurious_reg;
    if (take) begin
      spurious_next = 1'b0;
    end
    if (!cpu_status_reg[`MIC_BIT_GLOBAL_DIS] && wr_status &&
        ((|(en_cleared & flag_events)) ||
         (periph_group_enable && !reg_wdata[`MIC_BIT_PERIPH_EN] && (|periph_set)))) begin
      spurious_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      irq_status_ctrl_reg <= `MIC_RST_STATUS_CTRL;
      cpu_status_reg <= `MIC_RST_CPU_STATUS;
      periph_irq_request_reg <= `MIC_RST_PERIPH_REQ;
      periph_irq_enable_reg <= `MIC_RST_PERIPH_EN;
      edge_cfg_reg <= `MIC_RST_EDGE_CFG;
      spurious_reg <= 1'b0;
    end else begin
      irq_status_ctrl_reg <= irq_status_ctrl_next;
      cpu_status_reg <= cpu_status_next;
      periph_irq_request_reg <= periph_irq_request_next;
      spurious_reg <= spurious_next;
      if (reg_wr && (reg_addr == `MIC_OFS_PERIPH_EN)) begin
        periph_irq_enable_reg <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `MIC_OFS_EDGE_CFG)) begin
        edge_cfg_reg <= {6'h00, reg_wdata[1:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MIC_OFS_STATUS_CTRL: begin
          reg_rdata <= {periph_pending_flag, irq_status_ctrl_reg[6:0]};
        end
        `MIC_OFS_CPU_STATUS: reg_rdata <= cpu_status_reg;
        `MIC_OFS_PERIPH_REQ: reg_rdata <= periph_irq_request_reg;
        `MIC_OFS_PERIPH_EN: reg_rdata <= periph_irq_enable_reg;
        `MIC_OFS_EDGE_CFG: reg_rdata <= edge_cfg_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Vector output and hardware stack
  // ----------------------------------------------------------------
  // Stack wraps on overflow like the core's own stack; no error is flagged
  always @(posedge clk) begin
    if (take) begin
      stack_mem[sp_reg] <= return_pc;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      sp_reg <= {SP_W{1'b0}};
      vec_take <= 1'b0;
      vec_addr <= {PC_W{1'b0}};
      pc_load <= 1'b0;
      pc_value <= {PC_W{1'b0}};
    end else begin
      vec_take <= take;
      pc_load <= 1'b0;
      if (take) begin
        sp_reg <= sp_step(sp_reg, 1'b1);
        case (src_sel)
          SRC_EXT: vec_addr <= `MIC_VEC_EXT;
          SRC_T0: vec_addr <= `MIC_VEC_T0;
          SRC_TCLK: vec_addr <= `MIC_VEC_TCLK;
          SRC_PERIPH: vec_addr <= `MIC_VEC_PERIPH;
          default: vec_addr <= `MIC_VEC_RESET;
        endcase
      end else if (return_from_irq_instr) begin
        sp_reg <= sp_step(sp_reg, 1'b0);
        pc_value <= stack_mem[sp_step(sp_reg, 1'b0)];
        pc_load <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== sim/mic_irq_ctrl_asserts.sv ====
// Port checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_asserts #(
  parameter PC_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic irq_req,
  input wire logic vec_take,
  input wire logic [PC_W-1:0] vec_addr,
  input wire logic pc_load,
  input wire logic global_irq_disable
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic take = irq_req && instr_boundary;
  property p_rst_dis; $rose(rstn) |-> global_irq_disable; endproperty
  a_rst_dis: assert property (p_rst_dis) else $error("disable not set by reset");
  property p_dis_blocks; global_irq_disable |-> !irq_req; endproperty
  a_dis_blocks: assert property (p_dis_blocks) else $error("request while disabled");
  property p_take; take |=> vec_take && global_irq_disable ##1 !vec_take; endproperty
  a_take: assert property (p_take) else $error("take without vector");
  property p_vec_set;
    vec_take |-> vec_addr inside {16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0020};
  endproperty
  a_vec_set: assert property (p_vec_set) else $error("illegal vector");
  property p_vec_cause; vec_take |-> $past(take); endproperty
  a_vec_cause: assert property (p_vec_cause) else $error("vector without take");
  property p_vec_hold; !vec_take |-> $stable(vec_addr); endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  property p_ret; return_from_irq_instr && !take |=> pc_load && !global_irq_disable; endproperty
  a_ret: assert property (p_ret) else $error("return did not pop");
  property p_pc_cause; pc_load |-> $past(return_from_irq_instr); endproperty
  a_pc_cause: assert property (p_pc_cause) else $error("pop without return");
  property p_rdata; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  c_spur: cover property (vec_take && vec_addr == 16'h0000);
  c_per: cover property (vec_take && vec_addr == 16'h0020);
  c_ret: cover property (pc_load);
endmodule
bind mic_irq_ctrl mic_irq_ctrl_asserts #(.PC_W(PC_W)) u_chk (.clk(clk), .rstn(rstn),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_boundary(instr_boundary),
  .return_from_irq_instr(return_from_irq_instr), .irq_req(irq_req), .vec_take(vec_take),
  .vec_addr(vec_addr), .pc_load(pc_load), .global_irq_disable(global_irq_disable));
`default_nettype wire

// ==== sim/mic_core_model.sv ====
// Core sequencer model: instruction boundaries and program counter
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic vec_take,
  input wire logic [15:0] vec_addr,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  output logic instr_boundary,
  output logic [15:0] return_pc
);
  logic ph;
  always @(posedge clk) begin
    if (!rstn) begin
      ph <= 1'b0;
      return_pc <= 16'h0100;
    end else begin
      ph <= slow && !ph;
      if (vec_take) begin
        return_pc <= vec_addr;
      end else if (pc_load) begin
        return_pc <= pc_value;
      end else if (instr_boundary) begin
        return_pc <= return_pc + 16'h0001;
      end
    end
  end
  assign instr_boundary = rstn && !ph;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic tck = 1'b0;
  logic [7:0] pb = 8'h00;
  logic t0 = 1'b0;
  logic [6:0] pev = 7'h00;
  logic ret = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic req, take, pcl, gdis, ib, rd_q;
  logic [15:0] va, pcv, rpc, last_pc;
  logic [7:0] q_rd[$];
  logic [15:0] q_vec[$];
  logic [15:0] q_pc[$];
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_vec = 0;
  int k, i, pbit;
  always #2.5 clk = ~clk;
  mic_irq_ctrl u_dut (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ext_irq_pin(ext),
    .timer_clk_input_pin(tck), .port_b_pins(pb), .timer0_ovf(t0), .periph_evt(pev),
    .instr_boundary(ib), .return_pc(rpc), .return_from_irq_instr(ret), .irq_req(req),
    .vec_take(take), .vec_addr(va), .pc_load(pcl), .pc_value(pcv),
    .global_irq_disable(gdis));
  mic_core_model u_core (.clk(clk), .rstn(rstn), .slow(slow), .vec_take(take),
    .vec_addr(va), .pc_load(pcl), .pc_value(pcv), .instr_boundary(ib), .return_pc(rpc));
  // ----------------------------------------------------------------
  // Tasks and result watcher
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    t0 <= 1'b0;
    pev <= 7'h00;
    ret <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_vec(input int n);
    idle(1);
    k = 0;
    while (n_vec < n && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (n_vec < n) chk("vec_count", 16'(n), 16'(n_vec));
  endtask
  task automatic rti;
    wr <= 1'b0;
    rd <= 1'b0;
    ret <= 1'b1;
    @(posedge clk);
    idle(3);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_q <= rd;
    last_pc <= rpc;
    if (rd_q && q_rd.size() > 0) chk("rdata", 16'(q_rd.pop_front()), 16'(rdata));
    if (take) begin
      n_vec <= n_vec + 1;
      q_pc.push_back(last_pc);
      chk("global_irq_disable", 16'h0001, 16'(gdis));
      if (q_vec.size() > 0) chk("vec_addr", q_vec.pop_front(), va);
      else chk("unexpected vector", 16'h0000, 16'h0001);
    end
    if (pcl && q_pc.size() > 0) chk("pc_value", q_pc.pop_back(), pcv);
    if (pcl) chk("global_irq_disable", 16'h0000, 16'(gdis));
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    k = $urandom(32'h5DAB);
    pbit = $urandom % 7;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc(8'h07, 8'h00);
    rdc(8'h06, 8'h10);
    rdc(8'h16, 8'h02);
    rdc(8'h17, 8'h00);
    rdc(8'h3A, 8'h00);
    bus(1'b1, 8'h07, 8'h80);
    rdc(8'h07, 8'h00);
    bus(1'b1, 8'h17, 8'h02);
    rdc(8'h07, 8'h80);
    bus(1'b1, 8'h16, 8'h00);
    rdc(8'h07, 8'h00);
    // Peripheral enables off so later status reads see no pending bit
    bus(1'b1, 8'h17, 8'h00);
    $display("register test done");
    // Events while globally disabled must still flag, never vector
    t0 <= 1'b1;
    pev <= 7'(1 << pbit);
    ext <= 1'b1;
    tck <= 1'b1;
    pb <= 8'($urandom) | 8'h01;
    bus(1'b1, 8'h05, 8'h03);
    idle(6);
    rdc(8'h07, 8'h70);
    rdc(8'h16, 8'h80 | 8'(1 << pbit));
    bus(1'b1, 8'h07, 8'h7F);
    idle(4);
    chk("irq_req", 16'h0000, 16'(req));
    $display("flag test done");
    q_vec = {16'h0008, 16'h0010, 16'h0018, 16'h0020};
    bus(1'b1, 8'h06, 8'h00);
    for (i = 0; i < 3; i++) begin
      wait_vec(i + 1);
      rdc(8'h07, 8'h0F | (8'h70 & 8'(8'h70 << (i + 1))));
      slow <= (i == 1);
      rti();
    end
    bus(1'b1, 8'h17, 8'(1 << pbit));
    wait_vec(4);
    rdc(8'h16, 8'h80 | 8'(1 << pbit));
    bus(1'b1, 8'h16, 8'h00);
    rti();
    idle(4);
    $display("vector test done");
    q_vec.push_back(16'h0000);
    t0 <= 1'b1;
    bus(1'b1, 8'h07, 8'h0D);
    wait_vec(5);
    rti();
    idle(4);
    $display("spurious test done");
    // Disable first, then clear enables beside an event: no reset vector
    bus(1'b1, 8'h06, 8'h10);
    bus(1'b1, 8'h05, 8'h00);
    t0 <= 1'b1;
    ext <= 1'b0;
    tck <= 1'b0;
    bus(1'b1, 8'h07, 8'h00);
    idle(6);
    rdc(8'h07, 8'h70);
    idle(2);
    chk("vec_count", 16'd5, 16'(n_vec));
    $display("disable test done");
    finish_test();
  end
endmodule
`default_nettype wire
